// ---- rtl/ddr2_prech_ref_pkg.sv ----
package ddr2_prech_ref_pkg;

    localparam int BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ROW_W = 14;
    localparam int CNT_W = 9;

    // times in ns, clock 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_PRECHARGE_TIME_NS = 15;
    localparam int ALL_BANK_PRECHARGE_TIME_NS = 18;
    localparam int REFRESH_CYCLE_TIME_NS = 128;
    localparam int SELF_REFRESH_EXIT_TO_NONREAD_NS = 138;
    // exit-to-read time is given in clocks
    localparam int SELF_REFRESH_EXIT_TO_READ_CLK = 200;

    // least times round up
    localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(
        (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RPA_CYC = CNT_W'(
        (ALL_BANK_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(
        (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'(
        (SELF_REFRESH_EXIT_TO_NONREAD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] XSRD_CYC =
        CNT_W'(SELF_REFRESH_EXIT_TO_READ_CLK);

    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_ACTIVE = 4'h3;
    localparam logic [3:0] CMD_NOP = 4'h7;

    typedef struct packed {
        logic [3:0] cmd;
        logic all_bank_select_bit;
        logic [BANK_W-1:0] bank_select_lines;
        logic clock_enable;
    } cmd_bus_t;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_SELF_REF = 2'b01,
        ST_EXIT = 2'b10
    } mode_t;

endpackage

// ---- rtl/ddr2_prech_ref.sv ----
`timescale 1ns/1ps
`default_nettype none

module ddr2_prech_ref (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // command bus from the controller
    input wire ddr2_prech_ref_pkg::cmd_bus_t cmd_i,
    // bank state
    output logic [ddr2_prech_ref_pkg::BANKS-1:0] bank_open_o,
    output logic [ddr2_prech_ref_pkg::BANKS-1:0] bank_ready_o,
    // refresh and self refresh state
    output logic refresh_busy_o,
    output logic [ddr2_prech_ref_pkg::ROW_W-1:0] refresh_row_o,
    output logic self_refresh_o,
    output logic dll_enable_o,
    output logic nonread_ok_o,
    output logic read_ok_o
);

    localparam int CW = ddr2_prech_ref_pkg::CNT_W;
    localparam int BW = ddr2_prech_ref_pkg::BANK_W;

    ddr2_prech_ref_pkg::mode_t mode_r, mode_nxt;
    logic cke_prev_r, cke_prev_nxt;
    logic [CW-1:0] ref_cnt_r, ref_cnt_nxt;
    logic [CW-1:0] exit_cnt_r, exit_cnt_nxt;
    logic [ddr2_prech_ref_pkg::ROW_W-1:0] row_r, row_nxt;
    logic [ddr2_prech_ref_pkg::BANKS-1:0] open_r, open_nxt;
    logic [CW-1:0] pre_cnt_r [ddr2_prech_ref_pkg::BANKS];
    logic [CW-1:0] pre_cnt_nxt [ddr2_prech_ref_pkg::BANKS];
    logic normal, is_pre, is_act, is_ref;

    ////////////////////////////////////////////////////////////////////////
    // command decode: only meaningful with clock enable high before

    always_comb begin
        // self refresh and exit ignore commands entirely
        normal = (mode_r == ddr2_prech_ref_pkg::ST_NORMAL) &&
            cke_prev_r;
        is_pre = normal && cmd_i.clock_enable &&
            cmd_i.cmd == ddr2_prech_ref_pkg::CMD_PRECHARGE;
        is_act = normal && cmd_i.clock_enable &&
            cmd_i.cmd == ddr2_prech_ref_pkg::CMD_ACTIVE;
        is_ref = normal && cmd_i.cmd == ddr2_prech_ref_pkg::CMD_REFRESH;
    end

    ////////////////////////////////////////////////////////////////////////
    // per bank open state and precharge timers

    for (genvar b = 0; b < ddr2_prech_ref_pkg::BANKS; b++) begin : g_bank
        logic hit;
        always_comb begin
            // select bit high overrides the bank lines
            hit = is_pre && (cmd_i.all_bank_select_bit ||
                cmd_i.bank_select_lines == BW'(b));
            open_nxt[b] = open_r[b];
            pre_cnt_nxt[b] = pre_cnt_r[b];
            if (pre_cnt_r[b] != '0) begin
                pre_cnt_nxt[b] = pre_cnt_r[b] - CW'(1);
            end
            if (hit) begin
                // restart even if idle or already precharging
                open_nxt[b] = 1'b0;
                pre_cnt_nxt[b] = cmd_i.all_bank_select_bit ?
                    ddr2_prech_ref_pkg::RPA_CYC :
                    ddr2_prech_ref_pkg::RP_CYC;
            end else if (is_act &&
                    cmd_i.bank_select_lines == BW'(b)) begin
                open_nxt[b] = 1'b1;
            end
        end
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                open_r[b] <= 1'b0;
                pre_cnt_r[b] <= '0;
            end else begin
                open_r[b] <= open_nxt[b];
                pre_cnt_r[b] <= pre_cnt_nxt[b];
            end
        end
        assign bank_ready_o[b] = !open_r[b] && pre_cnt_r[b] == '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh, self refresh and exit timing

    always_comb begin
        mode_nxt = mode_r;
        cke_prev_nxt = cmd_i.clock_enable;
        ref_cnt_nxt = (ref_cnt_r != '0) ? ref_cnt_r - CW'(1) : ref_cnt_r;
        exit_cnt_nxt = exit_cnt_r;
        row_nxt = row_r;
        if (is_ref) begin
            // one row per command, address inputs unused
            row_nxt = row_r + ddr2_prech_ref_pkg::ROW_W'(1);
            ref_cnt_nxt = ddr2_prech_ref_pkg::RFC_CYC;
            if (!cmd_i.clock_enable) begin
                mode_nxt = ddr2_prech_ref_pkg::ST_SELF_REF;
            end
        end
        unique case (mode_r)
            ddr2_prech_ref_pkg::ST_NORMAL: begin
            end
            ddr2_prech_ref_pkg::ST_SELF_REF: begin
                // internal refresh keeps data; only clock enable matters
                if (!cke_prev_r && cmd_i.clock_enable) begin
                    mode_nxt = ddr2_prech_ref_pkg::ST_EXIT;
                    exit_cnt_nxt = CW'(1);
                end
            end
            ddr2_prech_ref_pkg::ST_EXIT: begin
                if (exit_cnt_r < ddr2_prech_ref_pkg::XSRD_CYC) begin
                    exit_cnt_nxt = exit_cnt_r + CW'(1);
                end
                // re-entry after nonread time drops clock enable again
                if (!cmd_i.clock_enable &&
                        exit_cnt_r >= ddr2_prech_ref_pkg::XSNR_CYC) begin
                    mode_nxt = ddr2_prech_ref_pkg::ST_SELF_REF;
                end else if (exit_cnt_r >=
                        ddr2_prech_ref_pkg::XSRD_CYC) begin
                    mode_nxt = ddr2_prech_ref_pkg::ST_NORMAL;
                end
            end
            default: mode_nxt = ddr2_prech_ref_pkg::ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= ddr2_prech_ref_pkg::ST_NORMAL;
            cke_prev_r <= 1'b0;
            ref_cnt_r <= '0;
            exit_cnt_r <= '0;
            row_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            cke_prev_r <= cke_prev_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            exit_cnt_r <= exit_cnt_nxt;
            row_r <= row_nxt;
        end
    end

    assign bank_open_o = open_r;
    assign refresh_busy_o = ref_cnt_r != '0;
    assign refresh_row_o = row_r;
    assign self_refresh_o = mode_r == ddr2_prech_ref_pkg::ST_SELF_REF;
    // dll stays off only while in self refresh
    assign dll_enable_o = mode_r != ddr2_prech_ref_pkg::ST_SELF_REF;
    assign nonread_ok_o = mode_r == ddr2_prech_ref_pkg::ST_NORMAL ||
        (mode_r == ddr2_prech_ref_pkg::ST_EXIT &&
        exit_cnt_r >= ddr2_prech_ref_pkg::XSNR_CYC);
    assign read_ok_o = mode_r == ddr2_prech_ref_pkg::ST_NORMAL;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_enter;
        is_ref && !cmd_i.clock_enable;
    endsequence

    a_pre_closes: assert property (
        is_pre && cmd_i.all_bank_select_bit |=> open_r == '0)
        else $error("precharge did not close bank");
    a_all_bank_time: assert property (
        is_pre && cmd_i.all_bank_select_bit
        |=> pre_cnt_r[7] == ddr2_prech_ref_pkg::RPA_CYC)
        else $error("all-bank precharge time wrong");
    a_single_bank: assert property (
        is_pre && !cmd_i.all_bank_select_bit &&
        cmd_i.bank_select_lines == 3'h2
        |=> pre_cnt_r[2] == ddr2_prech_ref_pkg::RP_CYC &&
        $stable(open_r[3]))
        else $error("single bank precharge wrong");
    a_sr_entry: assert property (s_enter |=> self_refresh_o
        && !dll_enable_o)
        else $error("self refresh not entered");
    a_sr_ignore: assert property (
        self_refresh_o |=> $stable(open_r) && $stable(refresh_row_o))
        else $error("command taken in self refresh");
    a_exit_start: assert property (self_refresh_o && !cke_prev_r &&
        cmd_i.clock_enable |=> mode_r == ddr2_prech_ref_pkg::ST_EXIT
        && exit_cnt_r == 9'h001 && dll_enable_o)
        else $error("self refresh exit wrong");
    a_read_wait: assert property (
        $rose(mode_r == ddr2_prech_ref_pkg::ST_EXIT) |->
        !read_ok_o [*8])
        else $error("read allowed too early");
    a_refresh_busy: assert property (is_ref && cmd_i.clock_enable
        |=> refresh_busy_o [*8])
        else $error("refresh busy too short");
    a_row_step: assert property (is_ref |=>
        refresh_row_o == $past(refresh_row_o) + 14'h0001)
        else $error("refresh row not advanced");

endmodule

`default_nettype wire

// ---- bench/ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ctl_model (
    // clock
    input wire logic clk_sys_i,
    // command bus to the device
    output var ddr2_prech_ref_pkg::cmd_bus_t cmd_o
);
    initial cmd_o = '{4'h7, 1'b0, 3'h0, 1'b1};

    task automatic issue(input logic [3:0] c, input logic a,
                         input logic [2:0] b, input logic k);
        @(negedge clk_sys_i);
        cmd_o <= '{c, a, b, k};
    endtask

    // unused fields wander so a stale value is never trusted
    task automatic idle(input int n, input logic k);
        repeat (n) issue(4'h7, 1'($urandom), 3'($urandom), k);
    endtask

    task automatic pre(input logic a, input logic [2:0] b);
        issue(4'h2, a, b, 1'b1);
        // waits the all-bank time, which covers the single-bank one too
        idle(ddr2_prech_ref_pkg::RPA_CYC, 1'b1);
    endtask

    task automatic act(input logic [2:0] b);
        issue(4'h3, 1'b0, b, 1'b1);
    endtask

    task automatic refr();
        issue(4'h1, 1'($urandom), 3'($urandom), 1'b1);
        idle(ddr2_prech_ref_pkg::RFC_CYC, 1'b1);
    endtask

    task automatic sref(input int lo);
        pre(1'b1, 3'($urandom));
        issue(4'h1, 1'b0, 3'h0, 1'b0);
        // garbage while asleep, the device must not take it
        repeat (lo) begin
            issue(4'($urandom), 1'($urandom), 3'($urandom), 1'b0);
        end
        // nop, clock enable high until reads are legal
        idle(ddr2_prech_ref_pkg::XSRD_CYC + 2, 1'b1);
    endtask
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    ddr2_prech_ref_pkg::cmd_bus_t cmd_w;
    ddr2_prech_ref_pkg::cmd_bus_t c;
    logic [7:0] open_w, ready_w, m_open, e_rdy;
    logic [13:0] row_w;
    logic busy_w, sref_w, dll_w, nrd_w, rd_w, m_ckep;
    logic [2:0] b;
    logic sel_all;
    logic e_nrd;
    int errors = 0;
    int compares = 0;
    int m_tmr[8];
    int m_busy, m_row, m_mode, m_cnt;

    ctl_model ctl_model_i (.clk_sys_i(clk_sys_i), .cmd_o(cmd_w));
    ddr2_prech_ref ddr2_prech_ref_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .cmd_i(cmd_w), .bank_open_o(open_w), .bank_ready_o(ready_w),
        .refresh_busy_o(busy_w), .refresh_row_o(row_w),
        .self_refresh_o(sref_w), .dll_enable_o(dll_w),
        .nonread_ok_o(nrd_w), .read_ok_o(rd_w));

    initial forever #5 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////
    // reference model, stepped on the same edge as the design
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            m_open = '0;
            m_tmr = '{default: 0};
            m_busy = 0;
            m_row = 0;
            m_mode = 0;
            m_cnt = 0;
            m_ckep = 1'b0;
        end else begin
            c = cmd_w;
            foreach (m_tmr[i]) if (m_tmr[i] > 0) m_tmr[i]--;
            if (m_busy > 0) m_busy--;
            if (m_mode == 0 && m_ckep) begin
                // self refresh entry starts a refresh cycle as well
                if (c.cmd === 4'h1) begin
                    m_row = (m_row + 1) % 16384;
                    m_busy = ddr2_prech_ref_pkg::RFC_CYC;
                    if (!c.clock_enable) m_mode = 1;
                end else if (c.clock_enable && c.cmd === 4'h2) begin
                    foreach (m_tmr[i]) begin
                        if (c.all_bank_select_bit ||
                                i == c.bank_select_lines) begin
                            m_open[i] = 1'b0;
                            m_tmr[i] = c.all_bank_select_bit ?
                                ddr2_prech_ref_pkg::RPA_CYC :
                                ddr2_prech_ref_pkg::RP_CYC;
                        end
                    end
                end else if (c.clock_enable && c.cmd === 4'h3) begin
                    m_open[c.bank_select_lines] = 1'b1;
                end
            end else if (m_mode == 1 && !m_ckep && c.clock_enable) begin
                m_mode = 2;
                m_cnt = 1;
            end else if (m_mode == 2) begin
                // clock enable low after the nonread time goes back in
                if (!c.clock_enable &&
                        m_cnt >= ddr2_prech_ref_pkg::XSNR_CYC) begin
                    m_mode = 1;
                end else if (m_cnt >= ddr2_prech_ref_pkg::XSRD_CYC) begin
                    m_mode = 0;
                end else begin
                    m_cnt++;
                end
            end
            m_ckep = c.clock_enable;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // outputs are settled half a cycle after the edge
    always @(negedge clk_sys_i) begin
        for (int i = 0; i < 8; i++) e_rdy[i] = !m_open[i] && m_tmr[i] == 0;
        e_nrd = m_mode == 0 ||
            (m_mode == 2 && m_cnt >= ddr2_prech_ref_pkg::XSNR_CYC);
        chk(32'(ready_w), 32'(e_rdy));
        chk(32'(open_w), 32'(m_open));
        chk(32'(busy_w), 32'(m_busy > 0));
        chk(32'(row_w), 32'(m_row));
        chk(32'(sref_w), 32'(m_mode == 1));
        chk(32'(dll_w), 32'(m_mode != 1));
        chk(32'(nrd_w), 32'(e_nrd));
        chk(32'(rd_w), 32'(m_mode == 0));
    end

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1a47a4da));
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i <= 1'b0;
        // clock enable low, then one edge of history: both refused
        ctl_model_i.issue(4'h3, 1'b0, 3'h5, 1'b0);
        ctl_model_i.issue(4'h3, 1'b0, 3'h5, 1'b1);
        ctl_model_i.act(3'h6);
        for (int n = 0; n < 40; n++) begin
            b = 3'($urandom);
            sel_all = 1'($urandom_range(0, 3) == 0);
            ctl_model_i.act(b);
            // no read or write is sent in this loop, so no transfer is cut short
            ctl_model_i.act(3'($urandom));
            if (n[2]) ctl_model_i.issue(4'h2, 1'b0, b, 1'b1);
            ctl_model_i.pre(sel_all, b);
            ctl_model_i.idle(n % 3, 1'b1);
        end
        ctl_model_i.pre(1'b1, 3'h0);
        repeat (3) ctl_model_i.refr();
        ctl_model_i.sref(3);
        ctl_model_i.act(3'h2);
        ctl_model_i.sref(6);
        ctl_model_i.act(3'h4);
        // back to sleep once the nonread time has passed, then out again
        ctl_model_i.pre(1'b1, 3'h0);
        ctl_model_i.issue(4'h1, 1'b0, 3'h0, 1'b0);
        ctl_model_i.idle(3, 1'b0);
        ctl_model_i.idle(ddr2_prech_ref_pkg::XSNR_CYC + 1, 1'b1);
        ctl_model_i.idle(4, 1'b0);
        ctl_model_i.idle(ddr2_prech_ref_pkg::XSRD_CYC + 2, 1'b1);
        ctl_model_i.idle(3, 1'b1);
        give_verdict();
    end
endmodule

`default_nettype wire
